// ==== shared/ptio_pkg.sv ====
// Constants, register map and field layout of the pulse train input and output unit.
// What this block does
// - Input selector 1 feeds PID feedback, 2 PID target.
// - Pulse PID feedback needs feedback source 3.
// - Frequency-command input with PID needs source 3/4.
// - Output selector picks pulse output source 1-7.
// - Output scale sets frequency at 100 percent.
// - Selections 1-6: 100 percent is maximum frequency.
// - Selection 2, scale 0: follow output frequency.
// - Selection 7 repeats encoder pulses one-to-one.
// - Reference source 4 takes pulse input reference.
// - Input scale maps to maximum output frequency.
// - Gain and bias applied to scaled input.
// - Filter time smooths measured input frequency.
// - Terminal function 32 is the synchronization command.
// - Master emits reference, follower consumes it.
// - Direction comes from digital input terminals.
// - Input scale limited to 50-32000 Hz.
// - Filter time limited to 0.00-2.00 seconds.
// - Input bias limited to plus/minus 100.0 percent.
package ptio_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_FREQ_HZ = 200_000_000;
  localparam int unsigned GATE_TIME_MS = 1000;
  localparam int unsigned GATE_CYCLES_DFLT = CLK_FREQ_HZ / 1000 * GATE_TIME_MS;
  localparam logic [39:0] PHASE_INC_PER_DHZ =
    40'((64'h0000010000000000) / (64'(CLK_FREQ_HZ) * 64'h000000000000000a));

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_IN_SCALE = 8'h04;
  localparam logic [7:0] ADDR_IN_GAIN = 8'h08;
  localparam logic [7:0] ADDR_IN_BIAS = 8'h0c;
  localparam logic [7:0] ADDR_IN_FILT = 8'h10;
  localparam logic [7:0] ADDR_OUT_SCALE = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_IN_VALUE = 8'h1c;
  localparam logic [2:0] ADDR_MI_FUNC_PAGE = 3'h1;

  // ****************************************************************
  // Control fields
  // ****************************************************************
  localparam int unsigned CTRL_IN_FUNC_LSB = 0;
  localparam int unsigned CTRL_PID_USE_BIT = 2;
  localparam int unsigned CTRL_OUT_FUNC_LSB = 4;
  localparam int unsigned CTRL_FREQ_SRC_LSB = 8;
  localparam int unsigned CTRL_PID_FB_SRC_LSB = 12;
  localparam int unsigned CTRL_PID_TGT_SRC_LSB = 16;
  localparam int unsigned STAT_ERR_BIT = 24;
  localparam int unsigned STAT_DIR_REV_BIT = 25;
  localparam int unsigned STAT_SYNC_OK_BIT = 26;

  // ****************************************************************
  // Codes
  // ****************************************************************
  localparam logic [1:0] IN_FUNC_FREQ = 2'h0;
  localparam logic [1:0] IN_FUNC_PID_FB = 2'h1;
  localparam logic [1:0] IN_FUNC_PID_TGT = 2'h2;
  localparam logic [2:0] OUT_FUNC_FREQ_CMD = 3'h1;
  localparam logic [2:0] OUT_FUNC_OUT_FREQ = 3'h2;
  localparam logic [2:0] OUT_FUNC_SOFT_FREQ = 3'h3;
  localparam logic [2:0] OUT_FUNC_SPEED = 3'h4;
  localparam logic [2:0] OUT_FUNC_PID_FB = 3'h5;
  localparam logic [2:0] OUT_FUNC_PID_IN = 3'h6;
  localparam logic [2:0] OUT_FUNC_ENC_REPEAT = 3'h7;
  localparam logic [2:0] FREQ_SRC_PULSE = 3'h4;
  localparam logic [2:0] PID_FB_SRC_PULSE = 3'h3;
  localparam logic [2:0] PID_TGT_SRC_A = 3'h3;
  localparam logic [2:0] PID_TGT_SRC_B = 3'h4;
  localparam logic [5:0] MI_FUNC_FWD = 6'h00;
  localparam logic [5:0] MI_FUNC_REV = 6'h01;
  localparam logic [5:0] MI_FUNC_SYNC = 6'h20;
  localparam logic [5:0] MI_FUNC_RST = 6'h3f;

  // ****************************************************************
  // Limits and reset values
  // ****************************************************************
  localparam logic [15:0] IN_SCALE_MIN = 16'h0032;
  localparam logic [15:0] IN_SCALE_MAX = 16'h7d00;
  localparam logic [15:0] IN_SCALE_RST = 16'h03e8;
  localparam logic [13:0] IN_GAIN_MAX = 14'h2710;
  localparam logic [13:0] IN_GAIN_RST = 14'h03e8;
  localparam logic [15:0] IN_BIAS_MAX = 16'h03e8;
  localparam logic [15:0] IN_BIAS_MIN = 16'hfc18;
  localparam logic [7:0] IN_FILT_MAX = 8'hc8;
  localparam logic [7:0] FILT_STEP1 = 8'h19;
  localparam logic [7:0] FILT_STEP2 = 8'h32;
  localparam logic [7:0] FILT_STEP3 = 8'h64;
  localparam logic [15:0] OUT_SCALE_MAX = 16'h7d00;
  localparam logic [15:0] OUT_SCALE_RST = 16'h03e8;
  localparam logic [15:0] PCT_FULL = 16'h2710;
  localparam logic [31:0] CTRL_RST = 32'h00034310;

endpackage : ptio_pkg

// ==== verilog/ptio_top.sv ====
// Pulse train input measurement, scaling and pulse output generation.
`timescale 1ns/1ps
module ptio_top
  import ptio_pkg::*;
#(
  parameter int unsigned GATE_CYCLES = GATE_CYCLES_DFLT
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [31:0] regRdData,
  input wire logic pulseInTerminal,
  input wire logic encoderFeedback,
  input wire logic [7:0] multiInputTerminals,
  input wire logic [15:0] freqCmdPct,
  input wire logic [15:0] outFreqPct,
  input wire logic [15:0] softStartFreqPct,
  input wire logic [15:0] motorSpeedPct,
  input wire logic [15:0] pidFeedbackPct,
  input wire logic [15:0] pidInputPct,
  input wire logic [19:0] outFreqDeciHz,
  output logic pulseOutTerminal,
  output logic [15:0] freqRefPct,
  output logic freqRefValid,
  output logic [15:0] pidFbPct,
  output logic pidFbValid,
  output logic [15:0] pidTgtPct,
  output logic pidTgtValid,
  output logic paramSettingError,
  output logic runForward,
  output logic runReverse
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic pSync1;
    logic pSync2;
    logic pPrev;
    logic eSync1;
    logic eSync2;
    logic [7:0] miSync1;
    logic [7:0] miSync2;
    logic [1:0] inFunc;
    logic pidUse;
    logic [2:0] outFunc;
    logic [2:0] freqSrc;
    logic [2:0] pidFbSrc;
    logic [2:0] pidTgtSrc;
    logic [15:0] inScale;
    logic [13:0] inGain;
    logic [15:0] inBias;
    logic [7:0] inFilt;
    logic [15:0] outScale;
    logic [7:0][5:0] miFunc;
    logic [31:0] gateCnt;
    logic [19:0] edgeCnt;
    logic [19:0] measHz;
    logic [27:0] filtQ;
    logic [15:0] inValue;
    logic [15:0] freqRef;
    logic freqRefOk;
    logic [15:0] pidFb;
    logic pidFbOk;
    logic [15:0] pidTgt;
    logic pidTgtOk;
    logic err;
    logic fwd;
    logic rev;
    logic syncOk;
    logic [39:0] phase;
    logic pulseOut;
    logic [31:0] rdData;
  } ptio_state_t;

  ptio_state_t stReg;
  ptio_state_t stNext;

  // ****************************************************************
  // Terminal function decode
  // ****************************************************************
  logic [7:0] isSync;
  logic [7:0] isFwd;
  logic [7:0] isRev;

  generate
    for (genvar i = 0; i < 8; i++) begin : g_term
      assign isSync[i] = (stReg.miFunc[i] == MI_FUNC_SYNC);
      assign isFwd[i] = (stReg.miFunc[i] == MI_FUNC_FWD);
      assign isRev[i] = (stReg.miFunc[i] == MI_FUNC_REV);
    end
  endgenerate

  // ****************************************************************
  // Combinational working values
  // ****************************************************************
  logic rise;
  logic gateEnd;
  logic [2:0] filtShift;
  logic [19:0] measNow;
  logic signed [28:0] diffQ;
  logic [19:0] filtHz;
  logic [35:0] pctRaw;
  logic [51:0] gained;
  logic signed [53:0] biasTerm;
  logic signed [53:0] biased;
  logic [15:0] srcPct;
  logic [15:0] srcClamped;
  logic [31:0] tgtDHz;
  logic [39:0] phaseInc;
  logic syncHigh;
  logic fwdAct;
  logic revAct;
  logic [31:0] ctrlView;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    stNext = stReg;
    ctrlView = 32'h00000000;

    // Pin synchronisers.
    stNext.pSync1 = pulseInTerminal;
    stNext.pSync2 = stReg.pSync1;
    stNext.pPrev = stReg.pSync2;
    stNext.eSync1 = encoderFeedback;
    stNext.eSync2 = stReg.eSync1;
    stNext.miSync1 = multiInputTerminals;
    stNext.miSync2 = stReg.miSync1;

    // Edge counting over the gate interval.
    rise = stReg.pSync2 & ~stReg.pPrev;
    gateEnd = (stReg.gateCnt == 32'(GATE_CYCLES - 1));
    measNow = (stReg.edgeCnt == 20'hfffff) ? stReg.edgeCnt : stReg.edgeCnt + 20'(rise);
    if (gateEnd) begin
      stNext.gateCnt = 32'h00000000;
      stNext.edgeCnt = 20'h00000;
      stNext.measHz = measNow;
    end else begin
      stNext.gateCnt = stReg.gateCnt + 32'h00000001;
      stNext.edgeCnt = measNow;
    end

    // First order smoothing, heavier for longer filter times.
    if (stReg.inFilt == 8'h00) begin
      filtShift = 3'h0;
    end else if (stReg.inFilt <= FILT_STEP1) begin
      filtShift = 3'h1;
    end else if (stReg.inFilt <= FILT_STEP2) begin
      filtShift = 3'h2;
    end else if (stReg.inFilt <= FILT_STEP3) begin
      filtShift = 3'h3;
    end else begin
      filtShift = 3'h4;
    end
    diffQ = $signed({1'b0, stReg.measHz, 8'h00}) - $signed({1'b0, stReg.filtQ});
    if (gateEnd) begin
      stNext.filtQ = 28'($signed({1'b0, stReg.filtQ}) + (diffQ >>> filtShift));
    end

    // Scaling to percent of maximum frequency, then gain and bias.
    filtHz = stReg.filtQ[27:8];
    pctRaw = (36'(filtHz) * 36'h000002710) / 36'(stReg.inScale);
    gained = (52'(pctRaw) * 52'(stReg.inGain)) / 52'h00000000003e8;
    biasTerm = 54'($signed(stReg.inBias)) * $signed(54'h0000000000000a);
    biased = $signed({2'b00, gained}) + biasTerm;
    if (biased < 0) begin
      stNext.inValue = 16'h0000;
    end else if (biased > $signed(54'h0000000000ffff)) begin
      stNext.inValue = 16'hffff;
    end else begin
      stNext.inValue = biased[15:0];
    end

    // Synchronization command and run direction from the terminals.
    syncHigh = |(isSync & stReg.miSync2);
    stNext.syncOk = ~(|isSync) | syncHigh;
    fwdAct = |(isFwd & stReg.miSync2);
    revAct = |(isRev & stReg.miSync2);
    stNext.fwd = fwdAct & ~revAct;
    stNext.rev = revAct & ~fwdAct;

    // Routing of the scaled input value.
    stNext.freqRefOk = (stReg.freqSrc == FREQ_SRC_PULSE) && (stReg.inFunc == IN_FUNC_FREQ)
      && stReg.syncOk;
    stNext.freqRef = stNext.freqRefOk ? stReg.inValue : 16'h0000;
    stNext.pidFbOk = (stReg.inFunc == IN_FUNC_PID_FB);
    stNext.pidFb = stNext.pidFbOk ? stReg.inValue : 16'h0000;
    stNext.pidTgtOk = (stReg.inFunc == IN_FUNC_PID_TGT);
    stNext.pidTgt = stNext.pidTgtOk ? stReg.inValue : 16'h0000;

    // Parameter consistency check.
    stNext.err = ((stReg.inFunc == IN_FUNC_PID_FB) && (stReg.pidFbSrc != PID_FB_SRC_PULSE))
      || ((stReg.inFunc == IN_FUNC_FREQ) && stReg.pidUse
      && (stReg.pidTgtSrc != PID_TGT_SRC_A) && (stReg.pidTgtSrc != PID_TGT_SRC_B));

    // Pulse output source selection.
    unique case (stReg.outFunc)
      OUT_FUNC_FREQ_CMD: srcPct = freqCmdPct;
      OUT_FUNC_OUT_FREQ: srcPct = outFreqPct;
      OUT_FUNC_SOFT_FREQ: srcPct = softStartFreqPct;
      OUT_FUNC_SPEED: srcPct = motorSpeedPct;
      OUT_FUNC_PID_FB: srcPct = pidFeedbackPct;
      OUT_FUNC_PID_IN: srcPct = pidInputPct;
      default: srcPct = 16'h0000;
    endcase
    srcClamped = (srcPct > PCT_FULL) ? PCT_FULL : srcPct;
    tgtDHz = (32'(srcClamped) * 32'(stReg.outScale)) / 32'h000003e8;
    if ((stReg.outFunc == OUT_FUNC_OUT_FREQ) && (stReg.outScale == 16'h0000)) begin
      tgtDHz = 32'(outFreqDeciHz);
    end
    phaseInc = 40'(40'(tgtDHz) * PHASE_INC_PER_DHZ);

    // Pulse output generation.
    if (stReg.outFunc == OUT_FUNC_ENC_REPEAT) begin
      stNext.phase = 40'h0000000000;
      stNext.pulseOut = stReg.eSync2;
    end else if ((stReg.outFunc == 3'h0) || (phaseInc == 40'h0000000000)) begin
      stNext.phase = 40'h0000000000;
      stNext.pulseOut = 1'b0;
    end else begin
      stNext.phase = stReg.phase + phaseInc;
      stNext.pulseOut = stReg.phase[39];
    end

    // Register writes with range limiting.
    if (regWrEn) begin
      if (regAddr == ADDR_CTRL) begin
        stNext.inFunc = regWrData[CTRL_IN_FUNC_LSB +: 2];
        stNext.pidUse = regWrData[CTRL_PID_USE_BIT];
        stNext.outFunc = regWrData[CTRL_OUT_FUNC_LSB +: 3];
        stNext.freqSrc = regWrData[CTRL_FREQ_SRC_LSB +: 3];
        stNext.pidFbSrc = regWrData[CTRL_PID_FB_SRC_LSB +: 3];
        stNext.pidTgtSrc = regWrData[CTRL_PID_TGT_SRC_LSB +: 3];
      end else if (regAddr == ADDR_IN_SCALE) begin
        if (regWrData[15:0] < IN_SCALE_MIN) begin
          stNext.inScale = IN_SCALE_MIN;
        end else if (regWrData[15:0] > IN_SCALE_MAX) begin
          stNext.inScale = IN_SCALE_MAX;
        end else begin
          stNext.inScale = regWrData[15:0];
        end
      end else if (regAddr == ADDR_IN_GAIN) begin
        stNext.inGain = (regWrData[15:0] > 16'(IN_GAIN_MAX)) ? IN_GAIN_MAX : regWrData[13:0];
      end else if (regAddr == ADDR_IN_BIAS) begin
        if ($signed(regWrData[15:0]) > $signed(IN_BIAS_MAX)) begin
          stNext.inBias = IN_BIAS_MAX;
        end else if ($signed(regWrData[15:0]) < $signed(IN_BIAS_MIN)) begin
          stNext.inBias = IN_BIAS_MIN;
        end else begin
          stNext.inBias = regWrData[15:0];
        end
      end else if (regAddr == ADDR_IN_FILT) begin
        stNext.inFilt = (regWrData[7:0] > IN_FILT_MAX) ? IN_FILT_MAX : regWrData[7:0];
      end else if (regAddr == ADDR_OUT_SCALE) begin
        stNext.outScale = (regWrData[15:0] > OUT_SCALE_MAX) ? OUT_SCALE_MAX
          : regWrData[15:0];
      end else if (regAddr[7:5] == ADDR_MI_FUNC_PAGE) begin
        stNext.miFunc[regAddr[4:2]] = regWrData[5:0];
      end
    end

    // Register reads, answered in the following cycle only.
    ctrlView[CTRL_IN_FUNC_LSB +: 2] = stReg.inFunc;
    ctrlView[CTRL_PID_USE_BIT] = stReg.pidUse;
    ctrlView[CTRL_OUT_FUNC_LSB +: 3] = stReg.outFunc;
    ctrlView[CTRL_FREQ_SRC_LSB +: 3] = stReg.freqSrc;
    ctrlView[CTRL_PID_FB_SRC_LSB +: 3] = stReg.pidFbSrc;
    ctrlView[CTRL_PID_TGT_SRC_LSB +: 3] = stReg.pidTgtSrc;
    stNext.rdData = 32'h00000000;
    if (regRdEn) begin
      if (regAddr == ADDR_CTRL) begin
        stNext.rdData = ctrlView;
      end else if (regAddr == ADDR_IN_SCALE) begin
        stNext.rdData = 32'(stReg.inScale);
      end else if (regAddr == ADDR_IN_GAIN) begin
        stNext.rdData = 32'(stReg.inGain);
      end else if (regAddr == ADDR_IN_BIAS) begin
        stNext.rdData = 32'(stReg.inBias);
      end else if (regAddr == ADDR_IN_FILT) begin
        stNext.rdData = 32'(stReg.inFilt);
      end else if (regAddr == ADDR_OUT_SCALE) begin
        stNext.rdData = 32'(stReg.outScale);
      end else if (regAddr == ADDR_STATUS) begin
        stNext.rdData[19:0] = stReg.measHz;
        stNext.rdData[STAT_ERR_BIT] = stReg.err;
        stNext.rdData[STAT_DIR_REV_BIT] = stReg.rev;
        stNext.rdData[STAT_SYNC_OK_BIT] = stReg.syncOk;
      end else if (regAddr == ADDR_IN_VALUE) begin
        stNext.rdData = 32'(stReg.inValue);
      end else if (regAddr[7:5] == ADDR_MI_FUNC_PAGE) begin
        stNext.rdData = 32'(stReg.miFunc[regAddr[4:2]]);
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stReg <= '0;
      stReg.inFunc <= CTRL_RST[CTRL_IN_FUNC_LSB +: 2];
      stReg.outFunc <= CTRL_RST[CTRL_OUT_FUNC_LSB +: 3];
      stReg.freqSrc <= CTRL_RST[CTRL_FREQ_SRC_LSB +: 3];
      stReg.pidFbSrc <= CTRL_RST[CTRL_PID_FB_SRC_LSB +: 3];
      stReg.pidTgtSrc <= CTRL_RST[CTRL_PID_TGT_SRC_LSB +: 3];
      stReg.inScale <= IN_SCALE_RST;
      stReg.inGain <= IN_GAIN_RST;
      stReg.outScale <= OUT_SCALE_RST;
      stReg.miFunc <= {8{MI_FUNC_RST}};
      stReg.syncOk <= 1'b1;
    end else begin
      stReg <= stNext;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign regRdData = stReg.rdData;
  assign pulseOutTerminal = stReg.pulseOut;
  assign freqRefPct = stReg.freqRef;
  assign freqRefValid = stReg.freqRefOk;
  assign pidFbPct = stReg.pidFb;
  assign pidFbValid = stReg.pidFbOk;
  assign pidTgtPct = stReg.pidTgt;
  assign pidTgtValid = stReg.pidTgtOk;
  assign paramSettingError = stReg.err;
  assign runForward = stReg.fwd;
  assign runReverse = stReg.rev;

endmodule : ptio_top

// ==== tb/ptio_top_sva.sv ====
// Port assertions of the pulse train unit.
`timescale 1ns/1ps
module ptio_top_sva
  import ptio_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [31:0] regRdData,
  input wire logic encoderFeedback,
  input wire logic pulseOutTerminal,
  input wire logic [15:0] freqRefPct,
  input wire logic freqRefValid,
  input wire logic pidFbValid,
  input wire logic pidTgtValid,
  input wire logic paramSettingError,
  input wire logic runForward,
  input wire logic runReverse
);
  // ****************
  // Control shadow
  // ****************
  logic [31:0] ctrlReg;
  logic [3:0] ageReg;
  logic errExp;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrlReg <= CTRL_RST;
      ageReg <= 4'hf;
    end else if (regWrEn && regAddr == ADDR_CTRL) begin
      ctrlReg <= regWrData;
      ageReg <= 4'h0;
    end else if (ageReg != 4'hf) begin
      ageReg <= ageReg + 4'h1;
    end
  end
  assign errExp = (ctrlReg[1:0] == IN_FUNC_PID_FB && ctrlReg[14:12] != PID_FB_SRC_PULSE) ||
    (ctrlReg[1:0] == IN_FUNC_FREQ && ctrlReg[2] && ctrlReg[18:16] != PID_TGT_SRC_A &&
    ctrlReg[18:16] != PID_TGT_SRC_B);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_err_level: assert property (ageReg >= 4'h2 |-> paramSettingError == errExp)
    else $error("setting error flag wrong");
  a_fb_valid: assert property (ageReg >= 4'h8 |-> pidFbValid == (ctrlReg[1:0] == 2'h1))
    else $error("feedback valid wrong");
  a_tgt_valid: assert property (ageReg >= 4'h8 |-> pidTgtValid == (ctrlReg[1:0] == 2'h2))
    else $error("target valid wrong");
  a_ref_source: assert property (freqRefValid && ageReg >= 4'h8 |->
    ctrlReg[10:8] == FREQ_SRC_PULSE && ctrlReg[1:0] == IN_FUNC_FREQ) else $error("ref source");
  a_ref_zero: assert property (!freqRefValid |-> freqRefPct == 16'h0000)
    else $error("reference not zero");
  a_enc_repeat: assert property (ageReg >= 4'h8 && ctrlReg[6:4] == OUT_FUNC_ENC_REPEAT |->
    pulseOutTerminal == $past(encoderFeedback, 3)) else $error("encoder repeat wrong");
  a_out_idle: assert property (ageReg >= 4'h8 && ctrlReg[6:4] == 3'h0 |-> !pulseOutTerminal)
    else $error("pulse output not idle");
  a_rd_stands: assert property (!$past(regRdEn) |-> regRdData == 32'h0)
    else $error("read data outside its cycle");
  a_rd_unmapped: assert property (regRdEn && regAddr >= 8'h40 |=> regRdData == 32'h0)
    else $error("unmapped read not zero");
  a_dir_excl: assert property (!(runForward && runReverse))
    else $error("both directions");
  c_enc: cover property (ctrlReg[6:4] == OUT_FUNC_ENC_REPEAT && $rose(pulseOutTerminal));
  c_err: cover property ($rose(paramSettingError));
  c_ref: cover property ($rose(freqRefValid));
endmodule : ptio_top_sva

bind ptio_top ptio_top_sva u_ptio_top_sva (.core_clk(core_clk), .sys_rst(sys_rst),
  .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
  .regRdData(regRdData), .encoderFeedback(encoderFeedback),
  .pulseOutTerminal(pulseOutTerminal), .freqRefPct(freqRefPct), .freqRefValid(freqRefValid),
  .pidFbValid(pidFbValid), .pidTgtValid(pidTgtValid), .paramSettingError(paramSettingError),
  .runForward(runForward), .runReverse(runReverse));

// ==== tb/ptio_pulse_gen.sv ====
// Pulse generator and encoder model at the far side.
`timescale 1ns/1ps
module ptio_pulse_gen (
  input wire logic core_clk,
  input wire logic enable,
  input wire logic [7:0] halfCycles,
  output logic pulseOut,
  output logic encOut
);
  logic [7:0] cntReg = 8'h00;
  initial {pulseOut, encOut} = 2'b00;
  // Square train whose half period is a whole number of clock cycles.
  always @(posedge core_clk) begin
    if (!enable) begin
      cntReg <= 8'h00;
      pulseOut <= 1'b0;
      encOut <= 1'b0;
    end else if (cntReg + 8'h01 >= halfCycles) begin
      cntReg <= 8'h00;
      pulseOut <= ~pulseOut;
      encOut <= ~encOut;
    end else begin
      cntReg <= cntReg + 8'h01;
    end
  end
endmodule : ptio_pulse_gen

// ==== tb/ptio_top_tb.sv ====
// Self-checking bench of the pulse train unit.
`timescale 1ns/1ps
module ptio_top_tb;
  import ptio_pkg::*;
  localparam int GATE = 1000;
  localparam int LIMIT = 70000;
  localparam logic [39:0] RST_TAB [9] = '{40'h0000034310, 40'h04000003e8, 40'h08000003e8,
    40'h0c00000000, 40'h1000000000, 40'h14000003e8, 40'h200000003f, 40'h3c0000003f,
    40'h4000000000};
  localparam logic [71:0] CLP_TAB [7] = '{72'h040000001400000032, 72'h0400009c4000007d00,
    72'h0c0000f8300000fc18, 72'h10000000ff000000c8, 72'h1400009c4000007d00,
    72'h080000300000002710, 72'h40ffffffff00000000};
  localparam logic [32:0] ERR_TAB [5] = '{33'h100004001, 33'h000003001, 33'h100050004,
    33'h000030004, 33'h000040004};
  localparam logic [3:0] DIR_TAB [4] = '{4'h6, 4'h9, 4'hc, 4'h0};
  localparam int HALF [4] = '{5, 10, 20, 25};
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWrEn = 1'b0, regRdEn = 1'b0, genEn = 1'b0;
  logic [7:0] halfCyc = 8'h0a;
  logic [7:0] terms = 8'h00;
  logic [15:0] qty [6] = '{default: 16'h0};
  logic [19:0] outDhz = 20'h0;
  logic [31:0] regRdData;
  logic [15:0] refPct, fbPct, tgtPct;
  logic pulseIn, encFb, pulseOut, refV, fbV, tgtV, errFlag, runFwd, runRev;
  int n_mismatch = 0, n_compared = 0, cycles = 0;
  int seed = 32'h0714;
  always #2.5 core_clk = ~core_clk;
  ptio_pulse_gen u_ptio_pulse_gen (.core_clk(core_clk), .enable(genEn), .halfCycles(halfCyc),
    .pulseOut(pulseIn), .encOut(encFb));
  ptio_top #(.GATE_CYCLES(GATE)) u_ptio_top (.core_clk(core_clk), .sys_rst(sys_rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .pulseInTerminal(pulseIn), .encoderFeedback(encFb),
    .multiInputTerminals(terms), .freqCmdPct(qty[0]), .outFreqPct(qty[1]),
    .softStartFreqPct(qty[2]), .motorSpeedPct(qty[3]), .pidFeedbackPct(qty[4]),
    .pidInputPct(qty[5]), .outFreqDeciHz(outDhz), .pulseOutTerminal(pulseOut),
    .freqRefPct(refPct), .freqRefValid(refV), .pidFbPct(fbPct), .pidFbValid(fbV),
    .pidTgtPct(tgtPct), .pidTgtValid(tgtV), .paramSettingError(errFlag),
    .runForward(runFwd), .runReverse(runRev));
  // ****************
  // Tasks
  // ****************
  task automatic wrap_up();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic check_val(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : check_val
  task automatic check_range(input string nm, input logic [31:0] lo, hi, seen);
    n_compared++;
    if ((seen >= lo && seen <= hi) !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, seen);
    end
  endtask : check_range
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge core_clk);
    regWrEn <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    #1 d = regRdData;
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  task automatic toggles(input int n, output logic [31:0] t);
    logic v;
    @(posedge core_clk);
    v = pulseOut;
    t = 32'h0;
    repeat (n) begin
      @(posedge core_clk);
      if (pulseOut !== v) t = 32'h1;
    end
  endtask : toggles
  task automatic period(output int p);
    int t0;
    logic prev;
    t0 = -1;
    p = 0;
    prev = 1'b1;
    for (int n = 0; n < 15000 && p == 0; n++) begin
      @(posedge core_clk);
      if (prev === 1'b0 && pulseOut === 1'b1) begin
        if (t0 < 0) t0 = n;
        else p = n - t0;
      end
      prev = pulseOut;
    end
  endtask : period
  function automatic int expf(input int c, input int s, input int g, input int b);
    int v;
    v = c * 10000 / s * g / 1000 + b * 10;
    return (v < 0) ? 0 : (v > 65535) ? 65535 : v;
  endfunction : expf
  // ****************
  // Main sequence
  // ****************
  initial begin
    logic [31:0] d;
    int c, h, s, g, b, f, p;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    foreach (RST_TAB[i]) begin
      rd(RST_TAB[i][39:32], d);
      check_val("reset value", RST_TAB[i][31:0], d);
    end
    foreach (CLP_TAB[i]) begin
      wr(CLP_TAB[i][71:64], CLP_TAB[i][63:32]);
      rd(CLP_TAB[i][71:64], d);
      check_val("clamped value", CLP_TAB[i][31:0], d);
    end
    foreach (ERR_TAB[i]) begin
      wr(ADDR_CTRL, ERR_TAB[i][31:0]);
      cyc(3);
      check_val("setting error", {31'h0, ERR_TAB[i][32]}, {31'h0, errFlag});
    end
    wr(ADDR_CTRL, 32'h00033410);
    wr(ADDR_IN_SCALE, 32'd50);
    wr(ADDR_IN_GAIN, 32'd1000);
    wr(ADDR_IN_BIAS, 32'h0);
    wr(ADDR_IN_FILT, 32'd200);
    genEn <= 1'b1;
    cyc(2 * GATE + 8);
    check_range("filtered ref", 1, 4999, {16'h0, refPct});
    wr(ADDR_IN_FILT, 32'h0);
    for (int i = 0; i < 6; i++) begin
      h = HALF[$unsigned($random(seed)) % 4];
      s = 50 + $unsigned($random(seed)) % 200;
      g = $unsigned($random(seed)) % 2001;
      b = $random(seed) % 101;
      if (i == 0) begin
        s = 50;
        g = 10000;
        b = -1000;
      end
      c = GATE / (2 * h);
      f = (i + 1) % 3;
      halfCyc <= h[7:0];
      wr(ADDR_CTRL, 32'h00033410 | f);
      wr(ADDR_IN_SCALE, s);
      wr(ADDR_IN_GAIN, g);
      wr(ADDR_IN_BIAS, {16'h0, b[15:0]});
      cyc(3 * GATE + 8);
      rd(ADDR_STATUS, d);
      check_range("pulse count", c - 1, c + 1, {12'h0, d[19:0]});
      d = {16'h0, (f == 0) ? refPct : (f == 1) ? fbPct : tgtPct};
      check_range("scaled input", expf(c - 1, s, g, b), expf(c + 1, s, g, b), d);
      check_val("valid flags", {29'h0, f == 0, f == 1, f == 2}, {29'h0, refV, fbV, tgtV});
    end
    wr(8'h20, 32'(MI_FUNC_FWD));
    wr(8'h24, 32'(MI_FUNC_REV));
    foreach (DIR_TAB[i]) begin
      terms <= {6'h0, DIR_TAB[i][3:2]};
      cyc(6);
      check_val("direction", {30'h0, DIR_TAB[i][1:0]}, {30'h0, runFwd, runRev});
    end
    wr(8'h28, 32'(MI_FUNC_SYNC));
    terms <= 8'h00;
    cyc(8);
    check_val("sync low", 32'h0, {31'h0, refV});
    terms <= 8'h04;
    cyc(8);
    check_val("sync high", 32'h1, {31'h0, refV});
    wr(ADDR_CTRL, 32'h00033310);
    cyc(8);
    check_val("other source", 32'h0, {31'h0, refV});
    wr(ADDR_OUT_SCALE, 32'd32000);
    for (int k = 7; k <= 12; k++) begin
      foreach (qty[j]) qty[j] <= (j == k % 6) ? PCT_FULL : 16'h0;
      wr(ADDR_CTRL, 32'h00033400 | ((k % 6 + 1) << 4));
      toggles(3200, d);
      check_val("output selected", 32'h1, d);
    end
    period(p);
    check_range("output period", 6188, 6313, p);
    wr(ADDR_CTRL, 32'h00033400);
    cyc(4);
    toggles(400, d);
    check_val("output off", 32'h0, d);
    foreach (qty[j]) qty[j] <= 16'h0;
    outDhz <= 20'd320000;
    wr(ADDR_OUT_SCALE, 32'h0);
    wr(ADDR_CTRL, 32'h00033420);
    toggles(3200, d);
    check_val("output follows", 32'h1, d);
    halfCyc <= 8'h07;
    wr(ADDR_CTRL, 32'h00033470);
    cyc(4);
    toggles(20, d);
    check_val("encoder repeat", 32'h1, d);
    wrap_up();
  end
endmodule : ptio_top_tb
